// >>> design/pipelined_sram_bus_control.sv
// device side of a synchronous pipelined burst sram port: pipeline, data register, output drive
`timescale 1ns/1ps
// Overview of operation
// - state advances on a clock rise only while clock_gate_n is low.
// - the device is selected when select one is low, select two high and select three low, sampled at the rise.
// - a high clock gate stretches the previous cycle without deselecting the device.
// - output enable high, sampled at an active rise, releases the data and parity pins after that rise; they then act as inputs.
// - outputs stay released during write data, the first clock out of deselect, and while deselected.
// - write data on the pins is captured into an internal data register at the rise.
// - read data comes from the address sampled at the rise that started the read.
// - parity lanes behave like data lanes and each is written only under its byte-write select.
// - the burst strap selects interleaved order when high, linear when low, and resets to interleaved.
// - active-low byte-write selects, qualified by write enable, choose the lanes written.
// - a deselect sampled at one rise releases the outputs after the next rise.
// - while the clock gate is high every internal state holds.
module pipelined_sram_bus_control
   import sram_bus_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic clock_gate_n_i,
   input wire logic chip_select_one_n_i,
   input wire logic chip_select_two_i,
   input wire logic chip_select_three_n_i,
   input wire logic write_enable_n_i,
   input wire logic advance_or_load_i,
   input wire sram_bus_pkg::lanes_t byte_write_n_i,
   input wire sram_bus_pkg::addr_t addr_i,
   input wire logic output_enable_n_i,
   input wire logic burst_mode_i,
   input wire sram_bus_pkg::data_t data_i,
   input wire sram_bus_pkg::lanes_t parity_i,
   output sram_bus_pkg::data_t data_o,
   output logic data_oe_o,
   output sram_bus_pkg::lanes_t parity_o,
   output logic parity_oe_o
);
   import sram_bus_pkg::*;

   logic active;
   logic select_in;
   // address stage
   logic sel1;
   logic we1;
   addr_t addr1;
   lanes_t bw1;
   burst_t base1;
   burst_t cnt1;
   // data stage
   logic sel2;
   logic we2;
   addr_t addr2;
   lanes_t bw2;
   // commit stage, fed by the data register
   logic wr3;
   addr_t addr3;
   lanes_t bw3;
   word_t wdata;
   logic mode;
   logic strap_taken;
   word_t pin_word;
   word_t mem_word;
   word_t rd_word;
   lanes_t lane_wr2;
   lanes_t lane_wr3;
   burst_t next_cnt;

   assign active = clk_en_i & ~clock_gate_n_i;
   assign select_in = ~chip_select_one_n_i & chip_select_two_i & ~chip_select_three_n_i;
   assign pin_word = {parity_i, data_i};
   assign next_cnt = burst_t'(cnt1 + BURST_STEP);

   // strap taken once after reset release; late changes are ignored by design
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         mode <= MODE_RESET;
         strap_taken <= 1'b0;
      end
      else if (active && !strap_taken)
      begin
         mode <= burst_mode_i;
         strap_taken <= 1'b1;
      end
   end

   // address stage: load on advance_or_load low, otherwise step the burst
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sel1 <= 1'b0;
         we1 <= 1'b0;
         addr1 <= '0;
         bw1 <= '1;
         base1 <= BURST_ZERO;
         cnt1 <= BURST_ZERO;
      end
      else if (active)
      begin
         bw1 <= byte_write_n_i;
         if (!advance_or_load_i)
         begin
            sel1 <= select_in;
            we1 <= ~write_enable_n_i;
            addr1 <= addr_i;
            base1 <= addr_i[BURST_W-1:0];
            cnt1 <= BURST_ZERO;
         end
         else
         begin
            // access type and selection persist through the burst
            cnt1 <= next_cnt;
            addr1[BURST_W-1:0] <= burst_low(base1, next_cnt, mode);
         end
      end
   end

   // data stage
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sel2 <= 1'b0;
         we2 <= 1'b0;
         addr2 <= '0;
         bw2 <= '1;
      end
      else if (active)
      begin
         sel2 <= sel1;
         we2 <= we1;
         addr2 <= addr1;
         bw2 <= bw1;
      end
   end

   // data register catches pin data in the write data phase, committed one clock later
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr3 <= 1'b0;
         addr3 <= '0;
         bw3 <= '1;
         wdata <= '0;
      end
      else if (active)
      begin
         wr3 <= sel2 & we2;
         addr3 <= addr2;
         bw3 <= bw2;
         if (sel2 && we2)
         begin
            wdata <= pin_word;
         end
      end
   end

   assign lane_wr2 = (sel2 && we2) ? ~bw2 : '0;
   assign lane_wr3 = wr3 ? ~bw3 : '0;

   sram_word_array u_array (
      .core_clk_i(core_clk_i),
      .write_i(active & wr3),
      .lane_en_i(lane_wr3),
      .write_addr_i(addr3),
      .write_word_i(wdata),
      .read_addr_i(addr1),
      .read_word_o(mem_word)
   );

   // forward writes not yet in the array so back-to-back write then read sees new data
   always_comb
   begin
      rd_word = mem_word;
      if (addr3 == addr1)
      begin
         rd_word = merge_lanes(rd_word, wdata, lane_wr3);
      end
      if (addr2 == addr1)
      begin
         rd_word = merge_lanes(rd_word, pin_word, lane_wr2);
      end
   end

   // output register loads only for a read; otherwise it holds its last value
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         data_o <= '0;
         parity_o <= '0;
      end
      else if (active && sel1 && !we1)
      begin
         data_o <= rd_word[DATA_W-1:0];
         parity_o <= rd_word[WORD_W-1:DATA_W];
      end
   end

   // output enable is sampled at the rise so the pin enable comes from a flop;
   // this trades the asynchronous response for a glitch-free registered drive.
   // the clock leaving deselect is the address clock, where the address stage still
   // holds the deselect, so drive is already off there
   always_ff @(posedge core_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         data_oe_o <= 1'b0;
         parity_oe_o <= 1'b0;
      end
      else if (active)
      begin
         data_oe_o <= sel1 & ~we1 & ~output_enable_n_i;
         parity_oe_o <= sel1 & ~we1 & ~output_enable_n_i;
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_read_start;
      active && !advance_or_load_i && select_in && write_enable_n_i;
   endsequence
   sequence s_deselect;
      active && !advance_or_load_i && !select_in;
   endsequence
   sequence s_write_start;
      active && !advance_or_load_i && select_in && !write_enable_n_i;
   endsequence

   a_gate_freeze: assert property (!active |=> $stable(data_o) && $stable(data_oe_o) && $stable(sel2))
      else $error("state changed while clock gated");
   a_output_hold: assert property (!active [*3] |-> $stable(parity_o) && $stable(data_o))
      else $error("output register moved during suspension");
   a_select_decode: assert property (active && !advance_or_load_i |=> sel1 == $past(select_in))
      else $error("chip select decode wrong");
   a_oe_release: assert property (active && output_enable_n_i |=> !data_oe_o && !parity_oe_o)
      else $error("pins driven with output enable high");
   a_write_quiet: assert property (sel2 && we2 |-> !data_oe_o)
      else $error("pins driven in write data phase");
   a_deselect_pipe: assert property (s_deselect ##1 active |=> !data_oe_o)
      else $error("deselect did not release outputs");
   a_read_path: assert property (s_read_start ##1 active && !output_enable_n_i |=> data_oe_o
      && {parity_o, data_o} == $past(rd_word))
      else $error("read data not from sampled address");
   a_data_capture: assert property (active && sel2 && we2 |=> wdata == $past(pin_word))
      else $error("write data not captured");
   a_lane_mask: assert property (s_write_start ##1 active [*2] |=> lane_wr3 == ~$past(byte_write_n_i, 3))
      else $error("lane written without its byte select");
   a_strap_fixed: assert property (strap_taken |=> $stable(mode))
      else $error("burst order changed after capture");
endmodule : pipelined_sram_bus_control

// >>> design/sram_bus_pkg.sv
// shared widths, layouts, reset values and helpers for the pipelined sram port
package sram_bus_pkg;
   localparam int ADDR_W = 18;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int DATA_W = LANES * LANE_W;
   localparam int WORD_W = DATA_W + LANES;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int BURST_W = 2;
   localparam logic MODE_RESET = 1'b1;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;

   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] data_t;
   typedef logic [LANES-1:0] lanes_t;
   typedef logic [WORD_W-1:0] word_t;
   typedef logic [BURST_W-1:0] burst_t;

   // word layout: parity bits sit above the data, parity bit k belongs to byte lane k
   function automatic word_t merge_lanes(word_t old_w, word_t new_w, lanes_t en);
      word_t r;
      r = old_w;
      for (int k = 0; k < LANES; k++)
      begin
         if (en[k])
         begin
            r[k*LANE_W +: LANE_W] = new_w[k*LANE_W +: LANE_W];
            r[DATA_W+k] = new_w[DATA_W+k];
         end
      end
      return r;
   endfunction : merge_lanes

   function automatic burst_t burst_low(burst_t base, burst_t cnt, logic interleave);
      burst_t r;
      r = interleave ? (base ^ cnt) : burst_t'(base + cnt);
      return r;
   endfunction : burst_low
endpackage : sram_bus_pkg

// >>> design/sram_word_array.sv
// flip-flop storage array with per-lane write mask and combinational read
`timescale 1ns/1ps
module sram_word_array
   import sram_bus_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic write_i,
   input wire sram_bus_pkg::lanes_t lane_en_i,
   input wire sram_bus_pkg::addr_t write_addr_i,
   input wire sram_bus_pkg::word_t write_word_i,
   input wire sram_bus_pkg::addr_t read_addr_i,
   output logic [sram_bus_pkg::WORD_W-1:0] read_word_o
);
   // storage carries no reset: contents are undefined until written
   word_t mem [0:DEPTH-1];

   always_ff @(posedge core_clk_i)
   begin
      if (write_i)
      begin
         mem[write_addr_i] <= merge_lanes(mem[write_addr_i], write_word_i, lane_en_i);
      end
   end

   assign read_word_o = mem[read_addr_i];
endmodule : sram_word_array

// >>> sim/host_bus_model.sv
// host side pin model: resolves the shared data and parity wires
`timescale 1ns/1ps
module host_bus_model
   import sram_bus_pkg::*;
(
   input wire logic core_clk_i,
   input wire sram_bus_pkg::word_t host_i,
   input wire logic drive_i,
   input wire sram_bus_pkg::data_t dq_i,
   input wire sram_bus_pkg::lanes_t dqp_i,
   input wire logic oe_i,
   input wire logic poe_i,
   output sram_bus_pkg::data_t pin_o,
   output sram_bus_pkg::lanes_t pinp_o,
   output logic clash_o
);
   word_t last;
   // no keeper on the wires, so a released bus never shows stale data
   always_ff @(posedge core_clk_i)
      last <= {pinp_o, pin_o};
   always_comb
   begin
      {pinp_o, pin_o} = ~last;
      if (drive_i)
         {pinp_o, pin_o} = host_i;
      if (oe_i)
         pin_o = dq_i;
      if (poe_i)
         pinp_o = dqp_i;
   end
   assign clash_o = drive_i & (oe_i | poe_i);
endmodule : host_bus_model

// >>> sim/testbench.sv
// self-checking bench for the pipelined sram port
`timescale 1ns/1ps
module testbench;
   import sram_bus_pkg::*;
   logic core_clk_i, resetn_i, clk_en_i, clock_gate_n_i, write_enable_n_i, advance_or_load_i;
   logic chip_select_one_n_i, chip_select_two_i, chip_select_three_n_i, output_enable_n_i, burst_mode_i;
   lanes_t byte_write_n_i, parity_i, parity_o;
   addr_t addr_i, base, bs;
   data_t data_i, data_o;
   logic data_oe_o, parity_oe_o, host_drive, clash, mode, brd, act;
   word_t host_word, pw [2];
   word_t mem [addr_t];
   word_t exp_q [$];
   logic [1:0] pv, bc;
   logic [37:0] held, got;
   logic [31:0] seed;
   logic [2:0] desel [3] = '{3'h3, 3'h0, 3'h6};
   int mismatches, samples_checked;

   pipelined_sram_bus_control dut_u (.*);
   host_bus_model host_u (.core_clk_i(core_clk_i), .host_i(host_word), .drive_i(host_drive), .dq_i(data_o),
      .dqp_i(parity_o), .oe_i(data_oe_o), .poe_i(parity_oe_o), .pin_o(data_i), .pinp_o(parity_i), .clash_o(clash));

   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic word_t rw();
      seed = lfsr(seed);
      return {seed[31:28], seed};
   endfunction : rw
   function automatic word_t merge(word_t o, word_t n, lanes_t bw);
      for (int k = 0; k < LANES; k++)
      begin
         if (!bw[k])
            {o[DATA_W+k], o[k*LANE_W +: LANE_W]} = {n[DATA_W+k], n[k*LANE_W +: LANE_W]};
      end
      return o;
   endfunction : merge

   task automatic cmp(logic [37:0] g, logic [37:0] e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic final_report();
      $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   task automatic do_reset(logic m);
      resetn_i = 1'h0;
      {burst_mode_i, mode} = {m, m};
      repeat (12) @(negedge core_clk_i);
      resetn_i = 1'h1;
   endtask : do_reset
   // one host cycle; g[0] lifts the clock gate, g[1] drops the core enable
   task automatic cyc(logic [1:0] g, logic [2:0] cs, logic we, logic adv, addr_t a, word_t w, lanes_t bw);
      @(negedge core_clk_i);
      {clk_en_i, clock_gate_n_i} = {~g[1], g[0]};
      {chip_select_one_n_i, chip_select_two_i, chip_select_three_n_i} = cs;
      {write_enable_n_i, advance_or_load_i, addr_i} = {we, adv, a};
      // lane selects are set every cycle: the core samples them at every active edge, load or advance
      byte_write_n_i = bw;
      {host_drive, host_word} = {pv[1], pw[1]};
      if (g != 2'h0)
         return;
      if (!adv)
         {bs, bc, brd} = {a, 2'h0, cs == 3'h2 && we};
      else
         bc = bc + 2'h1;
      if (!adv && cs == 3'h2 && !we)
         mem[a] = merge(mem[a], w, bw);
      if (brd && !output_enable_n_i)
         exp_q.push_back(mem[{bs[17:2], mode ? bs[1:0] ^ bc : bs[1:0] + bc}]);
      {pv, pw[1], pw[0]} = {pv[0], !adv && cs == 3'h2 && !we, pw[0], w};
   endtask : cyc
   task automatic rd(addr_t a);
      cyc(2'h0, 3'h2, 1'h1, 1'h0, a, '0, 4'hF);
   endtask : rd
   task automatic wr(addr_t a, lanes_t bw);
      cyc(2'h0, 3'h2, 1'h0, 1'h0, a, rw(), bw);
   endtask : wr
   task automatic idle(int n);
      repeat (n) cyc(2'h0, 3'h6, 1'h1, 1'h0, '0, '0, 4'hF);
   endtask : idle

   initial
   begin
      core_clk_i = 1'h0;
      forever #20 core_clk_i = ~core_clk_i;
   end
   // short cap: the whole sequence needs about 145 cycles
   initial
   begin
      repeat (1000) @(posedge core_clk_i);
      mismatches++;
      final_report();
   end
   always @(posedge core_clk_i)
   begin
      act = clk_en_i & ~clock_gate_n_i;
      if (resetn_i === 1'h1)
         cmp({37'h0, clash}, 38'h0);
      if (act)
         host_drive <= 1'h0;
      #1;
      got = {data_oe_o, parity_oe_o, parity_o, data_o};
      if (resetn_i === 1'h1 && !act)
         cmp(got, held);
      else if (resetn_i === 1'h1 && data_oe_o !== 1'h0)
         cmp(got, exp_q.size() > 0 ? {2'h3, exp_q.pop_front()} : 38'h0);
      held = got;
   end

   initial
   begin
      {clk_en_i, clock_gate_n_i, write_enable_n_i, advance_or_load_i, output_enable_n_i} = 5'h14;
      {chip_select_one_n_i, chip_select_two_i, chip_select_three_n_i} = 3'h6;
      {addr_i, byte_write_n_i, host_drive, host_word, pv} = '0;
      seed = 32'h4355C7F2;
      do_reset(1'h1);
      base = {seed[17:3], 3'h0};
      for (int i = 0; i < 8; i++)
         wr(base + addr_t'(i), 4'h0);
      for (int i = 0; i < 60; i++)
      begin
         seed = lfsr(seed);
         if (seed[9])
            wr(base + addr_t'(seed[2:0]), seed[7:4]);
         else
            rd(base + addr_t'(seed[2:0]));
      end
      idle(2);
      $display("test mix done");
      foreach (desel[j])
      begin
         cyc(2'h0, desel[j], 1'h1, 1'h0, base, '0, 4'hF);
         cyc(2'h0, desel[j], 1'h0, 1'h0, base, rw(), 4'h0);
         cyc(2'h0, 3'h2, 1'h1, 1'h1, base, '0, 4'hF);
         rd(base);
      end
      idle(2);
      $display("test select done");
      output_enable_n_i = 1'h1;
      rd(base + 18'h1);
      rd(base + 18'h2);
      idle(2);
      output_enable_n_i = 1'h0;
      $display("test enable done");
      wr(base + 18'h4, 4'h5);
      rd(base + 18'h2);
      cyc(2'h1, 3'h6, 1'h0, 1'h0, base + 18'h6, rw(), 4'h0);
      cyc(2'h2, 3'h6, 1'h0, 1'h0, base + 18'h6, rw(), 4'h0);
      rd(base + 18'h4);
      cyc(2'h1, 3'h2, 1'h1, 1'h0, base + 18'h7, '0, 4'hF);
      rd(base + 18'h3);
      idle(2);
      $display("test gating done");
      for (int m = 1; m >= 0; m--)
      begin
         do_reset(m[0]);
         rd(base + 18'h5);
         repeat (3) cyc(2'h0, 3'h6, 1'h1, 1'h1, '0, '0, 4'hF);
         idle(2);
      end
      $display("test burst done");
      cmp(38'(exp_q.size()), 38'h0);
      final_report();
   end
endmodule : testbench
